/* File: pkg/adc_ctrl_map.vh */
// Purpose: constants for the converter sequencing control block
// Assumes: byte addressed classic wishbone, 32-bit data lanes
// Notes:   register words sit at aligned byte offsets
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH

// register byte offsets
`define ADC_OFS_CTRL        4'h0
`define ADC_OFS_RESULT      4'h4
`define ADC_ADR_W           4

// control/status field positions
`define ADC_BIT_DONE        7
`define ADC_BIT_RC          6
`define ADC_BIT_PWR         5
`define ADC_CH_HI           4
`define ADC_CH_LO           0

// reset values
`define ADC_CTRL_RST        8'h00
`define ADC_RESULT_RST      8'h00

// channel codes
`define ADC_CH_EXT_LAST     5'h04
`define ADC_CH_REF_HI       5'h10
`define ADC_CH_REF_MID      5'h11
`define ADC_CH_REF_LO       5'h12
`define ADC_CH_TEST         5'h13

// timing
`define ADC_CLK_HZ          125000000
`define ADC_CONV_MIN_HZ     1000000
`define ADC_DIV_MAX         (`ADC_CLK_HZ / `ADC_CONV_MIN_HZ)
`define ADC_BUS_DIV         3'd4
`define ADC_CONV_CYCLES     5'd31
`define ADC_STEP_FIRST      5'd1
`define ADC_STEP_LAST       5'd9

`endif

/* File: rtl/adc_sequencing_control.v */
// Purpose: digital sequencing of an 8-bit successive approximation
//          converter with a wishbone register interface
// Assumes: analog mux, trial d/a and comparator sit outside;
//          rc oscillator output arrives asynchronously on rc_clk_i
// Notes:   conversion clock is clk_i divided or the rc oscillator

`timescale 1ns/1ps
`include "adc_ctrl_map.vh"

module adc_sequencing_control (
    input  wire                  clk_i,
    input  wire                  sys_rst_i,
    input  wire                  ce_i,
    input  wire                  wb_cyc_i,
    input  wire                  wb_stb_i,
    input  wire                  wb_we_i,
    input  wire [`ADC_ADR_W-1:0] wb_adr_i,
    input  wire [3:0]            wb_sel_i,
    input  wire [31:0]           wb_dat_i,
    output reg  [31:0]           wb_dat_o,
    output reg                   wb_ack_o,
    input  wire                  stop_mode_i,
    input  wire                  wait_mode_i,
    input  wire                  single_chip_i,
    input  wire                  rc_clk_i,
    input  wire                  comp_i,
    output reg                   rc_osc_enable_o,
    output reg                   charge_pump_on_o,
    output reg                   comparator_on_o,
    output reg  [4:0]            mux_select_o,
    output reg                   sample_o,
    output reg  [7:0]            dac_code_o
);

    // control/status fields
    reg        conversion_done_flag;
    reg        rc_clock_select;
    reg        converter_power_on;
    reg  [4:0] channel_select;
    reg  [7:0] conversion_result;

    // conversion sequencing
    reg        running;
    reg  [4:0] step;
    reg  [7:0] trial;
    reg  [2:0] div_cnt;
    reg  [2:0] bit_idx;

    // pins from outside the clock domain, after two flip-flops; rc_s3 after three
    wire       stop_s2;
    wire       rc_s2;
    wire       comp_s2;
    wire       chip_s2;
    reg        rc_s3;

    // bus decode
    wire       bus_req;
    wire       bus_wr;
    wire       bus_rd;
    wire       hit_ctrl;
    wire       hit_result;
    wire       ctrl_write;
    wire       result_read;
    wire [7:0] ctrl_view;

    // conversion clock
    wire       bus_tick;
    wire       rc_tick;
    wire       conv_tick;
    wire       conv_enable;
    wire       at_end;
    wire       in_steps;
    wire       code_valid;
    wire       code_zero;
    wire [7:0] final_code;
    wire [7:0] kept;

    assign bus_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr      = bus_req & wb_we_i & wb_sel_i[0];
    assign bus_rd      = bus_req & ~wb_we_i;
    assign hit_ctrl    = (wb_adr_i == `ADC_OFS_CTRL);
    assign hit_result  = (wb_adr_i == `ADC_OFS_RESULT);
    assign ctrl_write  = bus_wr & hit_ctrl;
    assign result_read = bus_rd & hit_result;

    assign ctrl_view = {conversion_done_flag,
                        rc_clock_select,
                        converter_power_on,
                        channel_select};

    // every pin from outside the clk_i domain passes two flip-flops
    pin_sync i_stop_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .pin_i     (stop_mode_i),
        .level_o   (stop_s2)
    );

    pin_sync i_rc_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .pin_i     (rc_clk_i),
        .level_o   (rc_s2)
    );

    pin_sync i_comp_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .pin_i     (comp_i),
        .level_o   (comp_s2)
    );

    pin_sync i_chip_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .pin_i     (single_chip_i),
        .level_o   (chip_s2)
    );

    // third rc stage holds the previous level for the edge detector
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rc_s3 <= 1'b0;
        end else if (ce_i) begin
            rc_s3 <= rc_s2;
        end
    end

    // bus clock path divides clk_i, still far above the 1 MHz floor
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_cnt <= 3'd0;
        end else if (ce_i) begin
            if (div_cnt == `ADC_BUS_DIV - 3'd1) begin
                div_cnt <= 3'd0;
            end else begin
                div_cnt <= div_cnt + 3'd1;
            end
        end
    end

    assign bus_tick  = (div_cnt == `ADC_BUS_DIV - 3'd1);
    // an rc period under two clk_i cycles would lose edges: a limit
    assign rc_tick   = rc_s2 & ~rc_s3;
    // rc edges are resampled on clk_i, so results land on clk_i edges
    assign conv_tick = rc_clock_select ? rc_tick : bus_tick;

    // wait mode deliberately has no term here: conversion runs on, and
    // wait_mode_i stays unread so wait entry can never touch the flag
    assign conv_enable = running & converter_power_on
                         & ~stop_s2;

    assign at_end   = (step == `ADC_CONV_CYCLES);
    assign in_steps = (step >= `ADC_STEP_FIRST) &&
                      (step <= `ADC_STEP_LAST);

    assign code_valid = (channel_select <= `ADC_CH_EXT_LAST) ||
                        (channel_select == `ADC_CH_REF_HI) ||
                        (channel_select == `ADC_CH_REF_MID) ||
                        (channel_select == `ADC_CH_REF_LO) ||
                        (channel_select == `ADC_CH_TEST);
    assign code_zero  = ~code_valid |
                        (chip_s2 &
                         (channel_select == `ADC_CH_TEST));
    assign final_code = code_zero ? 8'h00 : trial;

    // keep the trial bit while the comparator says input is not below it
    assign kept = comp_s2 ? dac_code_o : (dac_code_o & ~(8'h01 << bit_idx));

    // conversion sequencer: step 0 samples, steps 1..9 approximate,
    // step 31 hands the result over and the next conversion follows
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            step     <= 5'd0;
            trial    <= 8'h00;
            bit_idx  <= 3'd7;
            sample_o <= 1'b0;
        end else if (ce_i) begin
            sample_o <= 1'b0;
            if (ctrl_write || !conv_enable) begin
                // an aborted conversion restarts from the sample step
                step    <= 5'd0;
                trial   <= 8'h00;
                bit_idx <= 3'd7;
            end else if (conv_tick) begin
                step <= step + 5'd1;
                if (step == 5'd0) begin
                    sample_o <= 1'b1;
                    trial    <= 8'h00;
                    bit_idx  <= 3'd7;
                end else if (in_steps) begin
                    if (step != `ADC_STEP_FIRST) begin
                        trial   <= kept;
                        bit_idx <= bit_idx - 3'd1;
                    end
                end
            end
        end
    end

    // trial code to the d/a; ratiometric scaling is in the analog part
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dac_code_o <= 8'h00;
        end else if (ce_i) begin
            if (ctrl_write || !conv_enable) begin
                dac_code_o <= 8'h00;
            end else if (conv_tick) begin
                if (step == 5'd0) begin
                    dac_code_o <= 8'h00;
                end else if (step == `ADC_STEP_FIRST) begin
                    dac_code_o <= 8'h80;
                end else if (in_steps) begin
                    if (bit_idx == 3'd0) begin
                        dac_code_o <= kept;
                    end else begin
                        dac_code_o <= kept | (8'h01 << (bit_idx - 3'd1));
                    end
                end
            end
        end
    end

    // control register, result and done flag
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            conversion_done_flag <= 1'b0;
            rc_clock_select      <= 1'b0;
            converter_power_on   <= 1'b0;
            channel_select       <= 5'h00;
            conversion_result    <= `ADC_RESULT_RST;
            running              <= 1'b0;
        end else if (ce_i) begin
            if (ctrl_write) begin
                rc_clock_select    <= wb_dat_i[`ADC_BIT_RC];
                converter_power_on <= wb_dat_i[`ADC_BIT_PWR];
                channel_select     <= wb_dat_i[`ADC_CH_HI:`ADC_CH_LO];
                running            <= 1'b1;
            end
            // stop does not touch any register bit
            if (conv_enable && conv_tick && at_end && !ctrl_write) begin
                conversion_result    <= final_code;
                conversion_done_flag <= 1'b1;
            end else if (ctrl_write || result_read) begin
                // a completion wins over a result read in the same cycle, but a control write wins over a completion
                conversion_done_flag <= 1'b0;
            end
        end
    end

    // stop only gates the analog enables, never the stored bits
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rc_osc_enable_o  <= 1'b0;
            charge_pump_on_o <= 1'b0;
            comparator_on_o  <= 1'b0;
            mux_select_o     <= 5'h00;
        end else if (ce_i) begin
            rc_osc_enable_o  <= rc_clock_select & ~stop_s2;
            charge_pump_on_o <= converter_power_on & ~stop_s2;
            comparator_on_o  <= converter_power_on & ~stop_s2;
            mux_select_o     <= channel_select;
        end
    end

    // wishbone slave: ack one cycle after the strobe, zero when unmapped;
    // the registered ack costs a cycle per access but keeps the decode
    // off the ack path, and the ~ack term stops a held strobe re-firing
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce_i) begin
            wb_ack_o <= bus_req;
            if (bus_rd) begin
                if (hit_ctrl) begin
                    wb_dat_o <= {24'h000000, ctrl_view};
                end else if (hit_result) begin
                    wb_dat_o <= {24'h000000, conversion_result};
                end else begin
                    wb_dat_o <= 32'h00000000;
                end
            end
        end
    end

endmodule

// two-stage synchroniser for a level from outside the clk_i domain
module pin_sync (
    input  wire clk_i,
    input  wire sys_rst_i,
    input  wire ce_i,
    input  wire pin_i,
    output reg  level_o
);

    reg first;

    // only level_o may be read; first can go metastable
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            first   <= 1'b0;
            level_o <= 1'b0;
        end else if (ce_i) begin
            first   <= pin_i;
            level_o <= first;
        end
    end

endmodule

/* File: bench/adc_sequencing_control_chk.sv */
// Purpose: port level assertions for the converter sequencing control
// Assumes: ce_i held high, bus clock tick every 4 clk_i
// Notes:   rc ticks drift, so only bus clock periods are timed
`timescale 1ns/1ps
module adc_sequencing_control_chk (
    input logic        clk_i,
    input logic        sys_rst_i,
    input logic        ce_i,
    input logic        wb_cyc_i,
    input logic        wb_stb_i,
    input logic        wb_we_i,
    input logic [3:0]  wb_adr_i,
    input logic [3:0]  wb_sel_i,
    input logic [31:0] wb_dat_i,
    input logic [31:0] wb_dat_o,
    input logic        wb_ack_o,
    input logic        stop_mode_i,
    input logic        wait_mode_i,
    input logic        single_chip_i,
    input logic        rc_clk_i,
    input logic        comp_i,
    input logic        rc_osc_enable_o,
    input logic        charge_pump_on_o,
    input logic        comparator_on_o,
    input logic [4:0]  mux_select_o,
    input logic        sample_o,
    input logic [7:0]  dac_code_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic       req;
    logic       wr;
    logic [7:0] gap;
    logic       armed;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    // a write restarts the sequencer, so the gap across it is not timed
    assign wr = (req || wb_ack_o) && wb_we_i;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gap   <= 8'h00;
            armed <= 1'b0;
        end else begin
            gap   <= sample_o ? 8'h00 : gap + 8'h01;
            armed <= !wr && !stop_mode_i && (armed || sample_o);
        end
    end
    property p_ack; req |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
    a_hi: assert property (p_hi) else $error("upper bits set");
    property p_reset; $fell(sys_rst_i) |-> !wb_ack_o && !sample_o
        && !charge_pump_on_o && !rc_osc_enable_o; endproperty
    a_reset: assert property (p_reset) else $error("busy after reset");
    property p_stop_off; stop_mode_i [*5] |-> !rc_osc_enable_o
        && !charge_pump_on_o && !comparator_on_o; endproperty
    a_stop_off: assert property (p_stop_off) else $error("on in stop");
    property p_stop_idle; stop_mode_i [*5] |-> !sample_o; endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("no abort");
    property p_period; sample_o && armed && !rc_osc_enable_o
        |-> gap == 8'd127; endproperty
    a_period: assert property (p_period) else $error("bad period");
    property p_mux; req && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0]
        |-> ##2 mux_select_o == $past(wb_dat_i[4:0], 2); endproperty
    a_mux: assert property (p_mux) else $error("bad channel");
    property p_dac; (sample_o && !rc_osc_enable_o) ##0
        (!wb_we_i && !stop_mode_i) [*4] |=> dac_code_o == 8'h80
        && $past(dac_code_o, 4) == 8'h00; endproperty
    a_dac: assert property (p_dac) else $error("bad first trial");
    c_period: cover property (sample_o && armed);
    c_stop: cover property (stop_mode_i [*5]);
    c_rc: cover property (sample_o && rc_osc_enable_o);
endmodule

/* File: bench/adc_sequencing_control_bench.sv */
// Purpose: self-checking bench for the converter sequencing control
// Assumes: comparator answer held static for each conversion
// Notes:   rc oscillator stands in as clk_i divided by 16
`timescale 1ns/1ps
module adc_sequencing_control_bench;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        stop_mode_i = 1'b0;
    logic        wait_mode_i = 1'b0;
    logic        single_chip_i = 1'b0;
    logic        comp_i = 1'b0;
    logic [3:0]  wb_sel_i = 4'h1;
    logic        rc_osc_enable_o;
    logic        charge_pump_on_o;
    logic        comparator_on_o;
    logic [4:0]  mux_select_o;
    logic        sample_o;
    logic [7:0]  dac_code_o;
    logic [7:0]  want;
    logic [3:0]  rc_div = 4'h0;
    logic [31:0] q;
    int          num_errors = 0;
    int          comparisons = 0;
    logic [4:0]  codes [11] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04,
        5'h10, 5'h11, 5'h12, 5'h13, 5'h05, 5'h14};
    adc_sequencing_control i_adc_sequencing_control (
        .clk_i            (clk_i),
        .sys_rst_i        (sys_rst_i),
        .ce_i             (1'b1),
        .wb_cyc_i         (wb_cyc_i),
        .wb_stb_i         (wb_stb_i),
        .wb_we_i          (wb_we_i),
        .wb_adr_i         (wb_adr_i),
        .wb_sel_i         (wb_sel_i),
        .wb_dat_i         (wb_dat_i),
        .wb_dat_o         (wb_dat_o),
        .wb_ack_o         (wb_ack_o),
        .stop_mode_i      (stop_mode_i),
        .wait_mode_i      (wait_mode_i),
        .single_chip_i    (single_chip_i),
        .rc_clk_i         (rc_div[3]),
        .comp_i           (comp_i),
        .rc_osc_enable_o  (rc_osc_enable_o),
        .charge_pump_on_o (charge_pump_on_o),
        .comparator_on_o  (comparator_on_o),
        .mux_select_o     (mux_select_o),
        .sample_o         (sample_o),
        .dac_code_o       (dac_code_o)
    );
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) rc_div <= rc_div + 4'h1;
    task automatic give_verdict();
        if (num_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic we, input logic [3:0] a,
                        input logic [7:0] d);
        int n;
        logic got;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        got = (wb_ack_o === 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
        if (!got) begin
            num_errors++;
            give_verdict();
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        xfer(1'b0, a, 8'h00);
        chk(q, e);
    endtask
    // polls the flag: rc ticks are asynchronous, so no fixed count
    task automatic wait_done();
        int i;
        for (i = 0; i < 400; i++) begin
            xfer(1'b0, 4'h0, 8'h00);
            if (q[7] === 1'b1)
                break;
        end
        if (i == 400) begin
            num_errors++;
            give_verdict();
        end
    endtask
    task automatic conv(input logic [7:0] c, input logic cmp,
                        input logic [7:0] e);
        comp_i <= cmp;
        xfer(1'b1, 4'h0, c);
        wait_done();
        chk(q, {24'h0, 1'b1, c[6:0]});
        chk({30'h0, charge_pump_on_o, comparator_on_o}, 32'h3);
        chk({27'h0, mux_select_o}, {27'h0, c[4:0]});
        rd(4'h4, {24'h0, e});
        rd(4'h0, {24'h0, 1'b0, c[6:0]});
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        rd(4'h8, 32'h0);
        for (int k = 0; k < 11; k++) begin
            want = (k < 9) ? 8'hff : 8'h00;
            conv({3'b001, codes[k]}, 1'b1, want);
        end
        conv(8'h21, 1'b1, 8'hff);
        comp_i <= 1'b0;
        wait_mode_i <= 1'b1;
        repeat (300) @(posedge clk_i);
        rd(4'h0, 32'ha1);
        rd(4'h4, 32'h0);
        xfer(1'b1, 4'h0, 8'h01);
        repeat (200) @(posedge clk_i);
        rd(4'h0, 32'h01);
        chk({31'h0, charge_pump_on_o}, 32'h0);
        wait_mode_i <= 1'b0;
        single_chip_i <= 1'b1;
        conv(8'h33, 1'b1, 8'h00);
        single_chip_i <= 1'b0;
        xfer(1'b1, 4'h0, 8'h30);
        repeat (20) @(posedge clk_i);
        stop_mode_i <= 1'b1;
        repeat (300) @(posedge clk_i);
        rd(4'h0, 32'h30);
        rd(4'h4, 32'h0);
        stop_mode_i <= 1'b0;
        wait_done();
        rd(4'h4, 32'hff);
        conv(8'h70, 1'b1, 8'hff);
        chk({31'h0, rc_osc_enable_o}, 32'h1);
        xfer(1'b1, 4'h0, 8'h10);
        repeat (300) @(posedge clk_i);
        rd(4'h0, 32'h10);
        chk({31'h0, charge_pump_on_o}, 32'h0);
        chk({31'h0, rc_osc_enable_o}, 32'h0);
        xfer(1'b1, 4'h0, 8'h30);
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        rd(4'h0, 32'h0);
        wb_sel_i <= 4'h0;
        xfer(1'b1, 4'h0, 8'h3f);
        wb_sel_i <= 4'h1;
        rd(4'h0, 32'h0);
        give_verdict();
    end
endmodule
bind adc_sequencing_control adc_sequencing_control_chk i_chk (.*);
